// ==== hw/fgr_pkg.sv ====
// Purpose: Shared constants for the fuel gauge readback register bank.
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word.
// Notes:   Register indices are kept as printed; byte address is index * 4.
package fgr_pkg;

    // Bus geometry
    localparam int          ADDR_W       = 12;
    localparam int          DATA_W       = 32;
    localparam int          IDX_W        = ADDR_W - 2;

    // Register indices (byte address = index * 4)
    localparam logic [IDX_W-1:0] IDX_CHARGE_HI    = 10'h060;
    localparam logic [IDX_W-1:0] IDX_CHARGE_LO    = 10'h061;
    localparam logic [IDX_W-1:0] IDX_VCELL_HI     = 10'h062;
    localparam logic [IDX_W-1:0] IDX_VCELL_LO     = 10'h063;
    localparam logic [IDX_W-1:0] IDX_EMPTY_HI     = 10'h064;
    localparam logic [IDX_W-1:0] IDX_EMPTY_LO     = 10'h065;
    localparam logic [IDX_W-1:0] IDX_AVGV_HI      = 10'h066;
    localparam logic [IDX_W-1:0] IDX_AVGV_LO      = 10'h067;
    localparam logic [IDX_W-1:0] IDX_FULL_HI      = 10'h068;
    localparam logic [IDX_W-1:0] IDX_FULL_LO      = 10'h069;
    localparam logic [IDX_W-1:0] IDX_VALID_FLAGS  = 10'h06a;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS   = 10'h080;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK     = 10'h081;

    // Field positions in the result valid flags register
    localparam int          BIT_CHARGE_OK = 0;
    localparam int          BIT_VCELL_OK  = 1;
    localparam int          BIT_EMPTY_OK  = 2;
    localparam int          BIT_AVGV_OK   = 3;
    localparam int          BIT_FULL_OK   = 4;
    localparam int          BIT_SNIFF_EN  = 5;
    localparam int          BIT_DBG_RDY   = 7;
    localparam int          NUM_RESULTS   = 5;

    // Reset values
    localparam logic [15:0] RESULT_RST    = 16'h0000;
    localparam logic [4:0]  FLAGS_RST     = 5'h00;
    localparam logic        SNIFF_EN_RST  = 1'b1;
    localparam logic [7:0]  IRQ_RST       = 8'h00;

    // Event bits implemented in status and mask (ready flags and debug ready)
    localparam logic [7:0]  IRQ_IMPL      = 8'h9f;

    // Averaging window of the averaged cell voltage, in seconds
    localparam int          AVG_WINDOW_S  = 45;

    // AXI response codes
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : fgr_pkg

// ==== hw/fgr_regs.sv ====
// Purpose: Host-readable register bank holding fuel gauge results.
// Assumes: Gauge engine drives results and flags synchronous to clk.
// Notes:   Results refresh on a load pulse; reads never disturb state.
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Charge state: high byte 0x60, low 0x61
// - Cell voltage: high byte 0x62, low 0x63
// - Time to empty: high 0x64, low 0x65
// - Time to full: high 0x68, low 0x69
// - 45 second averaged voltage at 0x66/0x67
// - Flag bit 4: time to full reliable
// - Flag bit 3: averaged voltage reliable
// - Flag bit 2: time to empty reliable
// - Bit 0 charge, bit 1 voltage reliable
// - Bit 5 sniffer enable, writable, resets one
// - Bit 7 debug port ready, bit 6 unused
module fgr_regs
    import fgr_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    // AXI4-Lite write response
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address and data
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [DATA_W-1:0] rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    // Gauge engine results
    input  wire logic              resultLoad,
    input  wire logic [15:0]       chargeIn,
    input  wire logic [15:0]       vcellIn,
    input  wire logic [15:0]       emptyIn,
    input  wire logic [15:0]       avgVcellIn,
    input  wire logic [15:0]       fullIn,
    input  wire logic [4:0]        reliableIn,
    input  wire logic              dbgReadyIn,
    // Control and interrupt
    output var  logic              sniffEnable,
    output var  logic              irq
);

    // Stored results and flags
    logic [15:0]       chargeState;
    logic [15:0]       cellVoltage;
    logic [15:0]       timeToEmpty;
    logic [15:0]       avgVoltage;
    logic [15:0]       timeToFull;
    logic [4:0]        reliable;
    logic              dbgReady;
    logic [7:0]        irqStatus;
    logic [7:0]        irqMask;

    // Write channel state
    logic [ADDR_W-1:0] wrAddr;
    logic [DATA_W-1:0] wrData;
    logic [3:0]        wrStrb;
    logic              haveAddr;
    logic              haveData;
    logic              wrFire;
    logic [IDX_W-1:0]  wrIdx;
    logic              wrLane0;

    // Read channel
    logic              rdFire;
    logic [DATA_W-1:0] next_rdata;
    logic [1:0]        next_rresp;

    // Interrupt events
    logic [7:0]        eventNow;
    logic [7:0]        eventPrev;
    logic [7:0]        eventRise;
    logic [7:0]        clearMask;

    // Word index of a byte address
    function automatic logic [IDX_W-1:0] regIndex(
        input logic [ADDR_W-1:0] addr
    );
        regIndex = addr[ADDR_W-1:2];
    endfunction : regIndex

    // Whether an index names a register of this bank
    function automatic logic isMapped(input logic [IDX_W-1:0] idx);
        isMapped = (idx >= IDX_CHARGE_HI && idx <= IDX_VALID_FLAGS)
                || idx == IDX_IRQ_STATUS || idx == IDX_IRQ_MASK;
    endfunction : isMapped

    // Valid flags register image
    function automatic logic [7:0] flagsByte(
        input logic [4:0] rel,
        input logic       sniff,
        input logic       dbg
    );
        flagsByte = {dbg, 1'b0, sniff, rel};
    endfunction : flagsByte

    // Write happens once address and data are both held
    assign wrFire  = haveAddr && haveData && !bvalid;
    assign wrIdx   = regIndex(wrAddr);
    assign wrLane0 = wrStrb[0];
    assign rdFire  = arvalid && arready;

    // Address phase of a write; taken in any order with data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            haveAddr <= 1'b0;
            wrAddr   <= '0;
            awready  <= 1'b0;
        end else if (wrFire) begin
            haveAddr <= 1'b0;
            awready  <= 1'b0;
        end else if (awvalid && awready) begin
            haveAddr <= 1'b1;
            wrAddr   <= awaddr;
            awready  <= 1'b0;
        end else begin
            awready  <= !haveAddr && !bvalid;
        end
    end

    // Data phase of a write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            haveData <= 1'b0;
            wrData   <= '0;
            wrStrb   <= '0;
            wready   <= 1'b0;
        end else if (wrFire) begin
            haveData <= 1'b0;
            wready   <= 1'b0;
        end else if (wvalid && wready) begin
            haveData <= 1'b1;
            wrData   <= wdata;
            wrStrb   <= wstrb;
            wready   <= 1'b0;
        end else begin
            wready   <= !haveData && !bvalid;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wrFire) begin
            bvalid <= 1'b1;
            bresp  <= isMapped(wrIdx) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Results refresh only from the engine, never from the bus
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chargeState <= RESULT_RST;
            cellVoltage <= RESULT_RST;
            timeToEmpty <= RESULT_RST;
            avgVoltage  <= RESULT_RST;
            timeToFull  <= RESULT_RST;
        end else if (resultLoad) begin
            chargeState <= chargeIn;
            cellVoltage <= vcellIn;
            timeToEmpty <= emptyIn;
            avgVoltage  <= avgVcellIn;
            timeToFull  <= fullIn;
        end
    end

    // Reliability flags and debug port status follow the engine
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reliable <= FLAGS_RST;
            dbgReady <= 1'b0;
        end else begin
            reliable <= reliableIn;
            dbgReady <= dbgReadyIn;
        end
    end

    // Sniffer enable is the only writable bit of the flags register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sniffEnable <= SNIFF_EN_RST;
        end else if (wrFire && wrLane0 && wrIdx == IDX_VALID_FLAGS) begin
            sniffEnable <= wrData[BIT_SNIFF_EN];
        end
    end

    // Rising ready flags and debug ready raise sticky events
    assign eventNow  = flagsByte(reliable, 1'b0, dbgReady);
    assign eventRise = eventNow & ~eventPrev & IRQ_IMPL;
    assign clearMask = (wrFire && wrLane0 && wrIdx == IDX_IRQ_STATUS)
                     ? wrData[7:0] : 8'h00;

    // Previous flag image for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eventPrev <= 8'h00;
        end else begin
            eventPrev <= eventNow;
        end
    end

    // Status clears by writing one; a new event beats the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irqStatus <= IRQ_RST;
        end else begin
            irqStatus <= (irqStatus & ~clearMask) | eventRise;
        end
    end

    // Interrupt mask, same layout as status
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irqMask <= IRQ_RST;
        end else if (wrFire && wrLane0 && wrIdx == IDX_IRQ_MASK) begin
            irqMask <= wrData[7:0] & IRQ_IMPL;
        end
    end

    // Level interrupt while any unmasked status bit is set
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus & irqMask);
        end
    end

    // Read data mux; pure selection so reads alter nothing
    always_comb begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        unique case (regIndex(araddr))
            IDX_CHARGE_HI:   next_rdata[7:0] = chargeState[15:8];
            IDX_CHARGE_LO:   next_rdata[7:0] = chargeState[7:0];
            IDX_VCELL_HI:    next_rdata[7:0] = cellVoltage[15:8];
            IDX_VCELL_LO:    next_rdata[7:0] = cellVoltage[7:0];
            IDX_EMPTY_HI:    next_rdata[7:0] = timeToEmpty[15:8];
            IDX_EMPTY_LO:    next_rdata[7:0] = timeToEmpty[7:0];
            IDX_AVGV_HI:     next_rdata[7:0] = avgVoltage[15:8];
            IDX_AVGV_LO:     next_rdata[7:0] = avgVoltage[7:0];
            IDX_FULL_HI:     next_rdata[7:0] = timeToFull[15:8];
            IDX_FULL_LO:     next_rdata[7:0] = timeToFull[7:0];
            IDX_VALID_FLAGS: next_rdata[7:0] =
                flagsByte(reliable, sniffEnable, dbgReady);
            IDX_IRQ_STATUS:  next_rdata[7:0] = irqStatus;
            IDX_IRQ_MASK:    next_rdata[7:0] = irqMask;
            default:         next_rresp = RESP_SLVERR;
        endcase
    end

    // Read address acceptance and data return
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= RESP_OKAY;
        end else if (rdFire) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
        end else begin
            arready <= !rvalid;
        end
    end

    // Checks
    sequence s_wr_both;
        wrFire;
    endsequence

    sequence s_rd_charge_hi;
        rdFire && regIndex(araddr) == IDX_CHARGE_HI;
    endsequence

    property p_resp_next(trig, resp);
        @(posedge clk) disable iff (reset) trig |=> resp;
    endproperty

    a_write_response: assert property (p_resp_next(wrFire, bvalid))
        else $error("write response missing");

    // Compare with the byte held at the read edge; a load may follow it
    a_charge_readback: assert property (
        @(posedge clk) disable iff (reset)
        s_rd_charge_hi |=> rvalid
                        && rdata == {24'h0, $past(chargeState[15:8])}
    ) else $error("charge high byte readback wrong");

    a_voltage_load: assert property (
        @(posedge clk) disable iff (reset)
        resultLoad |=> cellVoltage == $past(vcellIn)
                    && avgVoltage == $past(avgVcellIn)
    ) else $error("voltage results not loaded");

    a_times_load: assert property (
        @(posedge clk) disable iff (reset)
        resultLoad |=> timeToEmpty == $past(emptyIn)
                    && timeToFull == $past(fullIn)
    ) else $error("time results not loaded");

    a_flags_follow: assert property (
        @(posedge clk) disable iff (reset)
        ##1 reliable == $past(reliableIn) && dbgReady == $past(dbgReadyIn)
    ) else $error("ready flags do not follow engine");

    a_sniff_write: assert property (
        @(posedge clk) disable iff (reset)
        s_wr_both ##0 (wrLane0 && wrIdx == IDX_VALID_FLAGS)
        |=> sniffEnable == $past(wrData[BIT_SNIFF_EN])
    ) else $error("sniffer enable not written");

    a_ro_ignored: assert property (
        @(posedge clk) disable iff (reset)
        wrFire && !resultLoad |=> $stable(chargeState) && $stable(timeToFull)
    ) else $error("read-only result changed by write");

    a_read_quiet: assert property (
        @(posedge clk) disable iff (reset)
        rdFire && !resultLoad && !wrFire |=> $stable(chargeState)
                                          && $stable(sniffEnable)
    ) else $error("read disturbed stored state");

    // Set beats clear, so an event under a one-write is never lost
    a_event_wins: assert property (
        @(posedge clk) disable iff (reset)
        (eventRise[BIT_DBG_RDY] && clearMask[BIT_DBG_RDY])
        |=> irqStatus[BIT_DBG_RDY]
    ) else $error("event lost under clear");

    a_irq_level: assert property (
        @(posedge clk) disable iff (reset)
        |(irqStatus & irqMask) |=> irq
    ) else $error("interrupt not raised");

    // Interrupt drops once nothing unmasked remains
    a_irq_quiet: assert property (
        @(posedge clk) disable iff (reset)
        !(|(irqStatus & irqMask)) |=> !irq
    ) else $error("interrupt stuck high");

    a_rvalid_hold: assert property (
        @(posedge clk) disable iff (reset)
        rvalid && !rready |=> rvalid && $stable(rdata)
    ) else $error("read data dropped before taken");

endmodule : fgr_regs

`default_nettype wire

// ==== dv/fgr_engine_model.sv ====
// Purpose: Behavioural gauge engine feeding results and flags.
// Assumes: Bench requests loads and flag levels after a clock edge.
// Notes:   Result lines carry a moving pattern outside the load pulse.
`timescale 1ns/1ns
`default_nettype none
module fgr_engine_model
    import fgr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Bench requests
    input  wire logic        loadReq,
    input  wire logic [15:0] base,
    input  wire logic [4:0]  relReq,
    input  wire logic        dbgReq,
    // Results towards the register bank
    output var  logic        resultLoad,
    output var  logic [15:0] chargeIn,
    output var  logic [15:0] vcellIn,
    output var  logic [15:0] emptyIn,
    output var  logic [15:0] avgVcellIn,
    output var  logic [15:0] fullIn,
    output var  logic [4:0]  reliableIn,
    output var  logic        dbgReadyIn
);
    logic [15:0] noise;
    // Strobe and flag levels follow the requests one edge later
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resultLoad <= 1'b0;
            reliableIn <= 5'h00;
            dbgReadyIn <= 1'b0;
            noise      <= 16'h0000;
        end else begin
            resultLoad <= loadReq;
            reliableIn <= relReq;
            dbgReadyIn <= dbgReq;
            noise      <= noise + 16'h3b5d;
        end
    end
    // Values hold only in the strobe, so a late capture reads junk
    assign chargeIn   = resultLoad ? base : noise;
    assign vcellIn    = resultLoad ? base ^ 16'h0f0f : ~noise;
    assign emptyIn    = resultLoad ? base ^ 16'h00ff
                                   : noise ^ 16'h5a5a;
    assign avgVcellIn = resultLoad ? base ^ 16'hff00 : ~noise;
    assign fullIn     = resultLoad ? base ^ 16'hf0f0
                                   : noise + 16'h0001;
endmodule : fgr_engine_model
`default_nettype wire

// ==== dv/fuel_gauge_readback_regs_bench.sv ====
// Purpose: Self-checking bench for the gauge readback registers.
// Assumes: AXI4-Lite master tasks wait on each handshake.
// Notes:   Expected bytes follow the engine model's fixed patterns.
`timescale 1ns/1ns
`default_nettype none
module fuel_gauge_readback_regs_bench
    import fgr_pkg::*;
;
    logic              clk = 1'b0;
    logic              reset, loadReq, dbgReq;
    logic [3:0]        lane = 4'h1;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, resultLoad;
    logic              dbgReadyIn, sniffEnable, irq;
    logic [15:0]       chargeIn, vcellIn, emptyIn, avgVcellIn, fullIn, base;
    logic [4:0]        reliableIn, relReq;
    logic [1:0]        r;
    logic [31:0]       d;
    int                fail_count, total_checks;

    fgr_regs dut_u (
        .clk(clk), .reset(reset),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .resultLoad(resultLoad), .chargeIn(chargeIn), .vcellIn(vcellIn),
        .emptyIn(emptyIn), .avgVcellIn(avgVcellIn), .fullIn(fullIn),
        .reliableIn(reliableIn), .dbgReadyIn(dbgReadyIn),
        .sniffEnable(sniffEnable), .irq(irq)
    );
    fgr_engine_model eng_u (
        .clk(clk), .reset(reset), .loadReq(loadReq), .base(base),
        .relReq(relReq), .dbgReq(dbgReq), .resultLoad(resultLoad),
        .chargeIn(chargeIn), .vcellIn(vcellIn), .emptyIn(emptyIn),
        .avgVcellIn(avgVcellIn), .fullIn(fullIn),
        .reliableIn(reliableIn), .dbgReadyIn(dbgReadyIn)
    );

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    task automatic chkWord(input string n, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chkWord

    task automatic chkBit(input string n, input logic e, g);
        chkWord(n, {31'h0, e}, {31'h0, g});
    endtask : chkBit

    task automatic summarize;
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic lost(input string n);
        $display("MISMATCH %s expected answer seen timeout", n);
        fail_count++;
        summarize;
    endtask : lost

    // Write one byte: both channels offered together, held until taken
    task automatic axWrite(input logic [IDX_W-1:0] i, input logic [7:0] v);
        int n;
        @(posedge clk);
        awaddr  <= {i, 2'b00};
        wdata   <= {24'h0, v};
        wstrb   <= lane;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (n == 50) lost("bvalid");
        r = bresp;
        bready <= 1'b0;
    endtask : axWrite

    task automatic axRead(input logic [IDX_W-1:0] i);
        int n;
        @(posedge clk);
        araddr  <= {i, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (n == 50) lost("rvalid");
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axRead

    task automatic rdChk(input logic [IDX_W-1:0] i, input logic [7:0] e);
        axRead(i);
        chkWord($sformatf("reg %h", i), {24'h0, e}, d);
        chkWord("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    endtask : rdChk

    task automatic rdPair(input logic [IDX_W-1:0] i, input logic [15:0] e);
        rdChk(i, e[15:8]);
        rdChk(i + 10'h001, e[7:0]);
    endtask : rdPair

    task automatic load(input logic [15:0] b);
        @(posedge clk);
        base    <= b;
        loadReq <= 1'b1;
        @(posedge clk);
        loadReq <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : load

    task automatic sReset;
        chkBit("sniffEnable", 1'b1, sniffEnable);
        chkBit("irq", 1'b0, irq);
        for (int k = 0; k < 10; k++)
            rdChk(IDX_CHARGE_HI + k[IDX_W-1:0], 8'h00);
        rdChk(IDX_VALID_FLAGS, {3'b001, FLAGS_RST});
        rdChk(IDX_IRQ_MASK, IRQ_RST);
    endtask : sReset

    // Two loads, the second with boundary bytes, every pair read back
    task automatic sResults;
        logic [15:0] b;
        for (int j = 0; j < 2; j++) begin
            b = (j == 0) ? 16'h1234 : 16'h8001;
            load(b);
            rdPair(IDX_CHARGE_HI, b);
            rdPair(IDX_VCELL_HI, b ^ 16'h0f0f);
            rdPair(IDX_EMPTY_HI, b ^ 16'h00ff);
            rdPair(IDX_AVGV_HI, b ^ 16'hff00);
            rdPair(IDX_FULL_HI, b ^ 16'hf0f0);
        end
    endtask : sResults

    task automatic sReadOnly;
        for (int k = 0; k < 10; k++) begin
            axWrite(IDX_CHARGE_HI + k[IDX_W-1:0], 8'hff);
            chkWord("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
        end
        rdPair(IDX_CHARGE_HI, 16'h8001);
        rdPair(IDX_FULL_HI, 16'h8001 ^ 16'hf0f0);
        axWrite(10'h06b, 8'hff);
        chkWord("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        axRead(10'h06b);
        chkWord("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
        chkWord("rdata", 32'h0, d);
    endtask : sReadOnly

    // Walking reliable flags, debug ready, sniffer write and reset
    task automatic sFlags;
        logic [7:0] e;
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            relReq <= 5'h01 << k;
            dbgReq <= k[0];
            repeat (2) @(posedge clk);
            e = {k[0], 2'b01, 5'h01 << k};
            rdChk(IDX_VALID_FLAGS, e);
        end
        // A write without lane 0 must leave the enable alone
        lane = 4'h2;
        axWrite(IDX_VALID_FLAGS, 8'h00);
        lane = 4'h1;
        chkBit("sniffEnable", 1'b1, sniffEnable);
        axWrite(IDX_VALID_FLAGS, 8'hdf);
        rdChk(IDX_VALID_FLAGS, 8'h10);
        chkBit("sniffEnable", 1'b0, sniffEnable);
        axWrite(IDX_VALID_FLAGS, 8'h00);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chkBit("sniffEnable", 1'b1, sniffEnable);
        rdPair(IDX_CHARGE_HI, 16'h0000);
    endtask : sFlags

    task automatic waitIrq(input logic e);
        for (int n = 0; n < 8 && irq !== e; n++) @(posedge clk);
        chkBit("irq", e, irq);
    endtask : waitIrq

    // Raise, mask, unmask and clear the event interrupt
    task automatic sIrq;
        @(posedge clk);
        relReq <= 5'h00;
        axWrite(IDX_IRQ_STATUS, 8'hff);
        rdChk(IDX_IRQ_STATUS, 8'h00);
        @(posedge clk);
        relReq <= 5'h04;
        repeat (4) @(posedge clk);
        rdChk(IDX_IRQ_STATUS, 8'h04);
        chkBit("irq", 1'b0, irq);
        axWrite(IDX_IRQ_MASK, 8'hff);
        rdChk(IDX_IRQ_MASK, IRQ_IMPL);
        waitIrq(1'b1);
        axWrite(IDX_IRQ_STATUS, 8'h04);
        waitIrq(1'b0);
        rdChk(IDX_IRQ_STATUS, 8'h00);
        @(posedge clk);
        dbgReq <= 1'b1;
        waitIrq(1'b1);
        rdChk(IDX_IRQ_STATUS, 8'h80);
        axWrite(IDX_IRQ_MASK, 8'h00);
        waitIrq(1'b0);
        // Debug ready rises in the very cycle its one-write clear lands
        @(posedge clk);
        dbgReq <= 1'b0;
        repeat (3) @(posedge clk);
        dbgReq <= 1'b1;
        axWrite(IDX_IRQ_STATUS, 8'h80);
        rdChk(IDX_IRQ_STATUS, 8'h80);
    endtask : sIrq

    initial begin
        fail_count = 0;
        total_checks = 0;
        {reset, loadReq, dbgReq, awvalid, wvalid, bready} = 6'h21;
        {arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        {base, relReq} = '0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        sReset;
        sResults;
        sReadOnly;
        sFlags;
        sIrq;
        summarize;
    end
endmodule : fuel_gauge_readback_regs_bench
`default_nettype wire
